//--- rtl/ami_pkg.sv
package ami_pkg;

    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_POS    = 8'h08;
    localparam logic [7:0] REG_LATCH  = 8'h0c;
    localparam logic [7:0] REG_CMP    = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_WDOG   = 8'h18;
    localparam logic [7:0] REG_STEP   = 8'h1c;
    localparam logic [7:0] REG_COMM   = 8'h20;

    // Control register fields.
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_FB_ANALOG = 2;
    localparam int CTRL_AUX_GPIO  = 3;
    localparam int CTRL_RES_LSB   = 4;
    localparam int CTRL_IDX_ZERO  = 6;
    localparam int CTRL_LATCH_FALL = 7;
    localparam int CTRL_CMP_EN    = 8;
    localparam int CTRL_PD_FB     = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Motor kinds held in the mode field.
    localparam logic [1:0] MODE_SERVO = 2'h0;
    localparam logic [1:0] MODE_SINE  = 2'h1;
    localparam logic [1:0] MODE_STEP  = 2'h2;

    // Status register fields.
    localparam int ST_LATCH_FLAG = 0;
    localparam int ST_INDEX_FLAG = 1;
    localparam int ST_WD_TRIP    = 2;
    localparam int ST_AMP_EN     = 3;
    localparam int ST_STEP_ACT   = 4;
    localparam int ST_HALL_LSB   = 5;
    localparam int ST_AUX_LSB    = 8;

    // Step register fields.
    localparam int STEP_DIR = 16;
    localparam int STEP_RUN = 17;
    localparam logic [31:0] STEP_RESET = 32'h0000_0000;

    // Watchdog kick key.
    localparam logic [7:0] WD_KEY = 8'h5a;

    // Timing.
    localparam int CLK_PERIOD_NS  = 40;
    localparam int STEP_HIGH_NS   = 2000;
    localparam int STEP_HIGH_CYC  = (STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_TIMEOUT_US  = 10000;
    localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int HALL_SETTLE_CYC = 7;

endpackage : ami_pkg

//--- rtl/ami_quad.sv
`timescale 1ns/100ps
// Turns filtered encoder levels into single-cycle up and down count pulses.
module ami_quad (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic pd_mode_i,
    input  wire logic a_i,
    input  wire logic b_i,
    output logic      up_o,
    output logic      dn_o
);

    logic prev_a_r;
    logic prev_b_r;
    logic [3:0] trans;
    logic quad_up;
    logic quad_dn;
    logic pd_edge;

    // Previous levels, for edge and transition detection.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_a_r <= 1'b0;
            prev_b_r <= 1'b0;
        end else if (ce_i) begin
            prev_a_r <= a_i;
            prev_b_r <= b_i;
        end
    end

    // A leading B walks 00-10-11-01; a double change matches neither list.
    assign trans   = {prev_a_r, prev_b_r, a_i, b_i};
    assign quad_up = (trans == 4'h2) || (trans == 4'hb) || (trans == 4'hd) || (trans == 4'h4);
    assign quad_dn = (trans == 4'h1) || (trans == 4'h7) || (trans == 4'he) || (trans == 4'h8);
    // Pulse and direction feedback counts each rising pulse edge.
    assign pd_edge = a_i && !prev_a_r;
    assign up_o    = ce_i && (pd_mode_i ? (pd_edge && !b_i) : quad_up);
    assign dn_o    = ce_i && (pd_mode_i ? (pd_edge && b_i) : quad_dn);

endmodule : ami_quad

//--- rtl/ami_axis.sv
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module ami_axis #(
    parameter int WD_CYCLES  = ami_pkg::WD_TIMEOUT_CYC,
    parameter int COMM_SHIFT = 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Classic Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Encoder, latch, Hall and strap pins.
    input  wire logic        enc_phase_a_i,
    input  wire logic        enc_phase_b_i,
    input  wire logic        enc_index_i,
    input  wire logic        latch_in_i,
    input  wire logic [2:0]  hall_i,
    input  wire logic        hall_present_i,
    input  wire logic        comm_stored_i,
    input  wire logic        stepper_select_i,
    input  wire logic        aux_a_i,
    input  wire logic        aux_b_i,
    input  wire logic [15:0] analog_fb_i,
    // Motor outputs.
    output logic      [15:0] dac_a_o,
    output logic      [15:0] dac_b_o,
    output logic             step_o,
    output logic             dir_o,
    output logic             cmp_o,
    output logic             amp_enable_out_o,
    output logic             error_led_o
);

    localparam int NSYNC = 12;
    localparam logic [15:0] STEP_HIGH = 16'(ami_pkg::STEP_HIGH_CYC);
    localparam logic [31:0] WD_LIMIT  = 32'(WD_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] s3_r;
    logic [NSYNC-1:0] pin_r;

    assign pins_raw = {comm_stored_i, hall_present_i, aux_b_i, aux_a_i, stepper_select_i,
                       hall_i, latch_in_i, enc_index_i, enc_phase_b_i, enc_phase_a_i};

    // Three stages per pin; a level is accepted once the last two agree.
    // At 25 MHz the filter resolves edges spaced two or more clocks apart.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_r[gi]  <= 1'b0;
                    s2_r[gi]  <= 1'b0;
                    s3_r[gi]  <= 1'b0;
                    pin_r[gi] <= 1'b0;
                end else if (ce_i) begin
                    s1_r[gi] <= pins_raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        pin_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    wire       enc_a      = pin_r[0];
    wire       enc_b      = pin_r[1];
    wire       enc_idx    = pin_r[2];
    wire       latch_lvl  = pin_r[3];
    wire [2:0] hall       = pin_r[6:4];
    wire       step_sel   = pin_r[7];
    wire [1:0] aux_lvl    = pin_r[9:8];
    wire       hall_there = pin_r[10];
    wire       comm_saved = pin_r[11];

    ////////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic [31:0] ctrl_r;
    logic [15:0] cmd_r;
    logic [31:0] pos_r;
    logic [31:0] latch_pos_r;
    logic [31:0] cmp_val_r;
    logic [31:0] step_cfg_r;
    logic [3:0]  comm_off_r;
    logic        latch_flag_r;
    logic        index_flag_r;

    wire req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr      = req && wb_we_i;
    wire wr_ctrl = wr && (wb_adr_i == ami_pkg::REG_CTRL);
    wire wr_cmd  = wr && (wb_adr_i == ami_pkg::REG_CMD);
    wire wr_cmp  = wr && (wb_adr_i == ami_pkg::REG_CMP);
    wire wr_stat = wr && (wb_adr_i == ami_pkg::REG_STATUS);
    wire wr_wdog = wr && (wb_adr_i == ami_pkg::REG_WDOG);
    wire wr_step = wr && (wb_adr_i == ami_pkg::REG_STEP);
    wire wr_comm = wr && (wb_adr_i == ami_pkg::REG_COMM);

    // Applies the byte enables to a register's old value.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    wire [31:0] wmerge_ctrl = merge(ctrl_r, wb_dat_i, wb_sel_i);
    wire [31:0] wmerge_cmd  = merge({16'h0000, cmd_r}, wb_dat_i, wb_sel_i);
    wire [31:0] wmerge_cmp  = merge(cmp_val_r, wb_dat_i, wb_sel_i);
    wire [31:0] wmerge_step = merge(step_cfg_r, wb_dat_i, wb_sel_i);
    wire        clr_latch   = wr_stat && wb_sel_i[0] && wb_dat_i[ami_pkg::ST_LATCH_FLAG];
    wire        clr_index   = wr_stat && wb_sel_i[0] && wb_dat_i[ami_pkg::ST_INDEX_FLAG];
    wire        wd_kick     = wr_wdog && wb_sel_i[0] && (wb_dat_i[7:0] == ami_pkg::WD_KEY);

    // Software-written configuration.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r     <= ami_pkg::CTRL_RESET;
            cmd_r      <= 16'h0000;
            cmp_val_r  <= 32'h0000_0000;
            step_cfg_r <= ami_pkg::STEP_RESET;
        end else if (ce_i) begin
            if (wr_ctrl) ctrl_r <= wmerge_ctrl;
            if (wr_cmd) cmd_r <= wmerge_cmd[15:0];
            if (wr_cmp) cmp_val_r <= wmerge_cmp;
            if (wr_step) step_cfg_r <= wmerge_step;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and position.

    wire [1:0] mode     = ctrl_r[ami_pkg::CTRL_MODE_LSB +: 2];
    wire       step_act = (mode == ami_pkg::MODE_STEP) && step_sel;
    wire       sine_act = (mode == ami_pkg::MODE_SINE);
    wire       servo_act = (mode == ami_pkg::MODE_SERVO);

    logic cnt_up;
    logic cnt_dn;

    // Pulse and direction decoding is offered only to stepper axes.
    ami_quad u_quad (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .pd_mode_i (ctrl_r[ami_pkg::CTRL_PD_FB] && step_act),
        .a_i       (enc_a),
        .b_i       (enc_b),
        .up_o      (cnt_up),
        .dn_o      (cnt_dn)
    );

    logic idx_prev_r;
    logic latch_prev_r;

    wire idx_rise   = enc_idx && !idx_prev_r;
    wire idx_zero   = idx_rise && ctrl_r[ami_pkg::CTRL_IDX_ZERO];
    wire [31:0] pos_view = ctrl_r[ami_pkg::CTRL_FB_ANALOG]
                           ? {{16{analog_fb_i[15]}}, analog_fb_i} : pos_r;
    wire latch_edge = ctrl_r[ami_pkg::CTRL_LATCH_FALL] ? (!latch_lvl && latch_prev_r)
                                                       : (latch_lvl && !latch_prev_r);

    // Encoder count; an index mark wins over a count in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_r <= 32'h0000_0000;
        end else if (ce_i) begin
            if (idx_zero) begin
                pos_r <= 32'h0000_0000;
            end else if (cnt_up) begin
                pos_r <= pos_r + 32'h0000_0001;
            end else if (cnt_dn) begin
                pos_r <= pos_r - 32'h0000_0001;
            end
        end
    end

    // Latch capture and sticky flags; a new event beats a clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_prev_r   <= 1'b0;
            latch_prev_r <= 1'b0;
            latch_pos_r  <= 32'h0000_0000;
            latch_flag_r <= 1'b0;
            index_flag_r <= 1'b0;
        end else if (ce_i) begin
            idx_prev_r   <= enc_idx;
            latch_prev_r <= latch_lvl;
            if (latch_edge) latch_pos_r <= pos_view;
            latch_flag_r <= latch_edge || (latch_flag_r && !clr_latch);
            index_flag_r <= idx_rise || (index_flag_r && !clr_index);
        end
    end

    // Compare output pulses one cycle when a count moves the position off the target.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_o <= 1'b0;
        end else if (ce_i) begin
            cmp_o <= ctrl_r[ami_pkg::CTRL_CMP_EN] && (cnt_up || cnt_dn)
                     && (pos_r == cmp_val_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog and amplifier enable.

    logic [31:0] wd_cnt_r;
    logic        wd_run_r;
    logic        wd_trip_r;

    // Enable stays low from power-up until the first kick; a missed kick
    // latches the trip, which nothing but reset clears.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_cnt_r  <= 32'h0000_0000;
            wd_run_r  <= 1'b0;
            wd_trip_r <= 1'b0;
        end else if (ce_i) begin
            if (wd_kick && !wd_trip_r) begin
                wd_cnt_r <= 32'h0000_0000;
                wd_run_r <= 1'b1;
            end else if (wd_run_r && !wd_trip_r) begin
                wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
                if (wd_cnt_r == WD_LIMIT - 32'h0000_0001) wd_trip_r <= 1'b1;
            end
        end
    end

    // Enable and error light are registered outputs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_enable_out_o <= 1'b0;
            error_led_o      <= 1'b0;
        end else if (ce_i) begin
            amp_enable_out_o <= wd_run_r && !wd_trip_r;
            error_led_o      <= wd_trip_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Commutation phase.

    logic [2:0] settle_r;
    logic       seeded_r;
    logic [3:0] hall_off;

    // Hall sequence 1-3-2-6-4-5 mapped onto sixteen phase steps.
    always_comb begin
        case (hall)
            3'h1:    hall_off = 4'h0;
            3'h3:    hall_off = 4'h3;
            3'h2:    hall_off = 4'h5;
            3'h6:    hall_off = 4'h8;
            3'h4:    hall_off = 4'hb;
            3'h5:    hall_off = 4'hd;
            default: hall_off = 4'h0;
        endcase
    end

    // The Hall seed waits for the pin filters to settle after reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_r   <= 3'h0;
            seeded_r   <= 1'b0;
            comm_off_r <= 4'h0;
        end else if (ce_i) begin
            if (settle_r != 3'(ami_pkg::HALL_SETTLE_CYC)) settle_r <= settle_r + 3'h1;
            if (wr_comm && wb_sel_i[0]) begin
                comm_off_r <= wb_dat_i[3:0];
                seeded_r   <= 1'b1;
            end else if (!seeded_r && settle_r == 3'(ami_pkg::HALL_SETTLE_CYC)) begin
                seeded_r <= 1'b1;
                if (hall_there && comm_saved) comm_off_r <= hall_off;
            end
        end
    end

    wire [3:0] phase_a = comm_off_r + pos_r[COMM_SHIFT +: 4];
    wire [3:0] phase_b = phase_a + 4'h4;

    // Sixteen-step sine, full scale 127.
    function automatic logic signed [7:0] sine16(input logic [3:0] ph);
        case (ph)
            4'h0: return 8'sh00;
            4'h1: return 8'sh31;
            4'h2: return 8'sh5a;
            4'h3: return 8'sh75;
            4'h4: return 8'sh7f;
            4'h5: return 8'sh75;
            4'h6: return 8'sh5a;
            4'h7: return 8'sh31;
            4'h8: return 8'sh00;
            4'h9: return -8'sh31;
            4'ha: return -8'sh5a;
            4'hb: return -8'sh75;
            4'hc: return -8'sh7f;
            4'hd: return -8'sh75;
            4'he: return -8'sh5a;
            default: return -8'sh31;
        endcase
    endfunction : sine16

    wire signed [23:0] prod_a = $signed(cmd_r) * sine16(phase_a);
    wire signed [23:0] prod_b = $signed(cmd_r) * sine16(phase_b);

    // DACs: zero when the amplifier is disabled, so a trip also kills torque.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_a_o <= 16'h0000;
            dac_b_o <= 16'h0000;
        end else if (ce_i) begin
            if (!amp_enable_out_o || step_act) begin
                dac_a_o <= 16'h0000;
                dac_b_o <= 16'h0000;
            end else if (sine_act) begin
                dac_a_o <= prod_a[22:7];
                dac_b_o <= prod_b[22:7];
            end else begin
                dac_a_o <= servo_act ? cmd_r : 16'h0000;
                dac_b_o <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Step generator.

    logic [15:0] step_cnt_r;

    // A finer drive needs more steps per move, so the period shrinks with it.
    wire [1:0]  res_shift = ctrl_r[ami_pkg::CTRL_RES_LSB +: 2];
    wire [15:0] step_per  = step_cfg_r[15:0] >> res_shift;
    wire        step_go   = step_act && step_cfg_r[ami_pkg::STEP_RUN];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_cnt_r <= 16'h0000;
            step_o     <= 1'b0;
            dir_o      <= 1'b0;
        end else if (ce_i) begin
            if (!step_go || step_cnt_r >= step_per) begin
                step_cnt_r <= 16'h0000;
            end else begin
                step_cnt_r <= step_cnt_r + 16'h0001;
            end
            step_o <= step_go && (step_cnt_r < STEP_HIGH);
            dir_o  <= step_cfg_r[ami_pkg::STEP_DIR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge.

    wire [31:0] status = {22'h000000,
                          ctrl_r[ami_pkg::CTRL_AUX_GPIO] ? aux_lvl : 2'b00,
                          hall, step_act, amp_enable_out_o, wd_trip_r,
                          index_flag_r, latch_flag_r};
    wire [31:0] rd_mux = (wb_adr_i == ami_pkg::REG_CTRL)   ? ctrl_r :
                         (wb_adr_i == ami_pkg::REG_CMD)    ? {16'h0000, cmd_r} :
                         (wb_adr_i == ami_pkg::REG_POS)    ? pos_view :
                         (wb_adr_i == ami_pkg::REG_LATCH)  ? latch_pos_r :
                         (wb_adr_i == ami_pkg::REG_CMP)    ? cmp_val_r :
                         (wb_adr_i == ami_pkg::REG_STATUS) ? status :
                         (wb_adr_i == ami_pkg::REG_STEP)   ? step_cfg_r :
                         (wb_adr_i == ami_pkg::REG_COMM)   ? {28'h0000000, comm_off_r} :
                         32'h0000_0000;

    // One wait state; unmapped addresses read zero and are still acknowledged.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            if (req && !wb_we_i) wb_dat_o <= rd_mux;
        end
    end

endmodule : ami_axis

//--- sim/ami_axis_chk.sv
`timescale 1ns/100ps
module ami_axis_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        stepper_select_i,
    input wire logic [15:0] dac_a_o,
    input wire logic [15:0] dac_b_o,
    input wire logic        step_o,
    input wire logic        cmp_o,
    input wire logic        amp_enable_out_o,
    input wire logic        error_led_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus answers exactly one cycle after it takes a request, then drops the answer.
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
    // Amplifier stays off after reset; a trip holds the light and keeps it off.
    property p_rst_off; $fell(rst_i) |-> !amp_enable_out_o && !error_led_o && !step_o; endproperty
    a_rst_off: assert property (p_rst_off) else $error("outputs active after reset");
    property p_err_amp; error_led_o |-> !amp_enable_out_o; endproperty
    a_err_amp: assert property (p_err_amp) else $error("amp on while tripped");
    property p_err_hold; error_led_o |=> error_led_o; endproperty
    a_err_hold: assert property (p_err_hold) else $error("trip cleared without reset");
    // A disabled amplifier sees a zero command; two cycles cover the register lag.
    property p_dac_off; (!amp_enable_out_o)[*2] |-> dac_a_o == 16'h0 && dac_b_o == 16'h0; endproperty
    a_dac_off: assert property (p_dac_off) else $error("dac driven with amp off");
    property p_step_pin; (!stepper_select_i)[*8] |-> !step_o; endproperty
    a_step_pin: assert property (p_step_pin) else $error("step without select pin");
    property p_cmp; cmp_o |=> !cmp_o; endproperty
    a_cmp: assert property (p_cmp) else $error("compare pulse too long");
endmodule : ami_axis_chk
bind ami_axis ami_axis_chk i_ami_axis_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .stepper_select_i, .dac_a_o, .dac_b_o, .step_o, .cmp_o, .amp_enable_out_o,
    .error_led_o);

//--- sim/ami_enc_model.sv
`timescale 1ns/100ps
module ami_enc_model (
    input  wire logic clk_i,
    input  wire integer tgt_i,
    input  wire logic jam_i,
    output logic      a_o,
    output logic      b_o
);
    localparam logic [7:0] GRAY = 8'h78;
    int pos_r = 0;
    int hold_r = 0;
    // One state per eight cycles keeps the encoder far below the rated count rate.
    always @(posedge clk_i) begin
        hold_r <= (hold_r + 1) % 8;
        if (hold_r == 0 && tgt_i != pos_r) begin
            pos_r <= pos_r + ((tgt_i > pos_r) ? 1 : -1);
        end
    end
    // A leads B going up; jam flips both lines at once, an invalid step.
    assign {a_o, b_o} = GRAY[2 * (pos_r & 3) +: 2] ^ {2{jam_i}};
endmodule : ami_enc_model

//--- sim/test_axis_motor_interface.sv
`timescale 1ns/100ps
module test_axis_motor_interface;
    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]  wb_adr_i = 8'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q;
    logic        latch_in_i = 0, stepper_select_i = 0, aux_a_i = 0, aux_b_i = 0, jam = 0;
    logic [15:0] analog_fb_i = 16'h0, dac_a_o, dac_b_o;
    logic        wb_ack_o, enc_phase_a_i, enc_phase_b_i, step_o, dir_o, cmp_o;
    logic        amp_enable_out_o, error_led_o;
    logic        ce_i = 1, enc_index_i = 0;
    int          tgt = 0, bad_count = 0, n_compared = 0, hi, per, n;
    ami_axis #(.WD_CYCLES(2000)) i_ami_axis (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .enc_phase_a_i, .enc_phase_b_i, .enc_index_i, .latch_in_i, .hall_i(3'h0),
        .hall_present_i(1'b0), .comm_stored_i(1'b0), .stepper_select_i, .aux_a_i, .aux_b_i,
        .analog_fb_i, .dac_a_o, .dac_b_o, .step_o, .dir_o, .cmp_o, .amp_enable_out_o,
        .error_led_o);
    ami_enc_model i_ami_enc_model (.clk_i, .tgt_i(tgt), .jam_i(jam), .a_o(enc_phase_a_i),
        .b_o(enc_phase_b_i));
    // Free-running 25 MHz clock.
    always #20 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic wt(input int c);
        repeat (c) @(posedge clk_i);
    endtask : wt
    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++k < 50);
        rd_q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        chk(k < 50, 1'b1, "bus answer lost");
    endtask : wb
    task automatic kick;
        wb(1, ami_pkg::REG_WDOG, {24'h0, ami_pkg::WD_KEY});
    endtask : kick
    task automatic meas;
        n = 0;
        while (step_o !== 1'b1 && n++ < 2000) @(posedge clk_i);
        for (hi = 0; step_o === 1'b1 && hi < 2000; hi++) @(posedge clk_i);
        for (per = hi; step_o !== 1'b1 && per < 2000; per++) @(posedge clk_i);
    endtask : meas
    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1;
        wt(20);
        rst_i <= 0;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        chk(amp_enable_out_o, 1'b0, "amp on before first kick");
        wb(0, ami_pkg::REG_CTRL, 0);
        chk(rd_q, ami_pkg::CTRL_RESET, "ctrl reset value");
        wb(0, 8'hfc, 0);
        chk(rd_q, 32'h0, "unmapped read");
        wb(1, ami_pkg::REG_CMD, 32'h1234);
        kick();
        wt(4);
        chk(amp_enable_out_o, 1'b1, "amp off after kick");
        chk(dac_a_o, 16'h1234, "servo command");
        // A frozen block must not let the watchdog run out.
        ce_i <= 0;
        wt(2100);
        ce_i <= 1;
        chk(amp_enable_out_o, 1'b1, "state ran with enable low");
        wb(1, ami_pkg::REG_POS, 32'hff);
        wb(0, ami_pkg::REG_POS, 0);
        chk(rd_q, 32'h0, "position written");
        $display("test regs done");
    endtask : t_regs
    task automatic t_quad;
        wb(1, ami_pkg::REG_CMP, 3);
        wb(1, ami_pkg::REG_CTRL, 1 << ami_pkg::CTRL_CMP_EN);
        @(posedge clk_i);
        tgt <= 4;
        for (n = 0; cmp_o !== 1'b1 && n < 200; n++) @(posedge clk_i);
        chk(n < 200, 1'b1, "no compare pulse");
        wt(40);
        wb(0, ami_pkg::REG_POS, 0);
        chk(rd_q, 32'h4, "four counts per cycle");
        jam <= 1;
        wt(20);
        wb(0, ami_pkg::REG_POS, 0);
        chk(rd_q, 32'h4, "double change counted");
        jam <= 0;
        wt(20);
        tgt <= 1;
        wt(60);
        wb(0, ami_pkg::REG_POS, 0);
        chk(rd_q, 32'h1, "count down");
        latch_in_i <= 1;
        wt(10);
        wb(0, ami_pkg::REG_STATUS, 0);
        chk(rd_q[ami_pkg::ST_LATCH_FLAG], 1'b1, "latch flag");
        wb(0, ami_pkg::REG_LATCH, 0);
        chk(rd_q, 32'h1, "latched position");
        wb(1, ami_pkg::REG_CTRL, 1 << ami_pkg::CTRL_IDX_ZERO);
        enc_index_i <= 1;
        wt(10);
        wb(0, ami_pkg::REG_POS, 0);
        chk(rd_q, 32'h0, "index did not zero count");
        wb(0, ami_pkg::REG_STATUS, 0);
        chk(rd_q[ami_pkg::ST_INDEX_FLAG], 1'b1, "index flag");
        $display("test quad done");
    endtask : t_quad
    task automatic t_fb;
        kick();
        {analog_fb_i, aux_a_i, aux_b_i} <= {16'h8001, 2'b11};
        wb(1, ami_pkg::REG_CTRL, 32'hc);
        wt(6);
        wb(0, ami_pkg::REG_POS, 0);
        chk(rd_q, 32'hffff8001, "analog position");
        wb(0, ami_pkg::REG_STATUS, 0);
        chk(rd_q[9:8], 2'b11, "aux inputs");
        wb(1, ami_pkg::REG_CTRL, ami_pkg::MODE_SINE);
        wt(4);
        chk({dac_a_o, dac_b_o}, 32'h0000_120f, "sine commutation");
        $display("test fb done");
    endtask : t_fb
    task automatic t_step;
        kick();
        wb(1, ami_pkg::REG_STEP, 32'h3_00c8);
        wb(1, ami_pkg::REG_CTRL, ami_pkg::MODE_STEP);
        for (n = 0; n < 300 && step_o === 1'b0; n++) @(posedge clk_i);
        chk(n, 300, "step without select pin");
        kick();
        stepper_select_i <= 1;
        meas();
        chk(hi, ami_pkg::STEP_HIGH_CYC, "step high time");
        chk(per, 201, "step cycle at full resolution");
        chk({dir_o, dac_a_o}, 17'h1_0000, "direction and zero command");
        kick();
        wb(1, ami_pkg::REG_CTRL, ami_pkg::MODE_STEP | (1 << ami_pkg::CTRL_RES_LSB));
        meas();
        meas();
        chk(per, 101, "step cycle at half resolution");
        $display("test step done");
    endtask : t_step
    task automatic t_wd;
        wt(2100);
        chk({error_led_o, amp_enable_out_o}, 2'b10, "watchdog trip");
        kick();
        wt(10);
        chk(error_led_o, 1'b1, "trip cleared by kick");
        do_reset();
        wt(2);
        chk(error_led_o, 1'b0, "trip kept over reset");
        $display("test wd done");
    endtask : t_wd
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Main sequence; the hang guard sits far beyond the expected run length.
    initial begin
        do_reset();
        t_regs();
        t_quad();
        t_fb();
        t_step();
        t_wd();
        test_done();
    end
    initial begin
        #(40 * 20000);
        bad_count++;
        test_done();
    end
endmodule : test_axis_motor_interface
